// ==== rtl/mmuc_regs.sv ====
// mmu and operating mode register bank with fetch strobe and return fetch control
`timescale 1ns/100ps
// Notes on behaviour
// - bank base forms 19-bit bank area address
// - bank base clears on reset
// - logical space split into three areas
// - upper nibble starts common area one
// - common one start field resets all ones
// - lower nibble starts bank area
// - bank start field resets all ones
// - fetch strobe enable resets to one
// - enabled strobe marks fetch and acknowledge cycles
// - enabled mode fetches return once
// - disabled strobe stays high on fetches
// - disabled mode refetches return with strobe
// - relocation picks io block, upper byte zero
// - relocation bits clear on reset
// - halt bit set by write, cleared by write/reset
// - common base forms 20-bit common one address
module mmuc_regs (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [15:0] log_addr,
    input  wire logic        opcode_fetch,
    input  wire logic        interrupt_line_zero_ack,
    input  wire logic        nmi_ack_first,
    input  wire logic        return_from_interrupt_instr_fetched,
    output logic      [7:0]  io_rdata_q,
    output logic             io_hit_q,
    output logic      [19:0] phys_addr_q,
    output logic      [1:0]  area_q,
    output logic             fetch_cycle_strobe_n_q,
    output logic             return_from_interrupt_instr_refetch_q,
    output logic             return_from_interrupt_instr_single_q,
    output logic             io_halt_mode_q
);
    typedef enum logic [1:0] {MMUC_IDLE, MMUC_REFETCH} mmuc_return_from_interrupt_instr_e;

    logic [7:0] common1_base_q;
    logic [7:0] bank_base_q;
    logic [7:0] area_bounds_q;
    logic [7:0] opt_control_q;
    logic [7:0] io_control_q;
    mmuc_return_from_interrupt_instr_e return_from_interrupt_instr_state_q;
    mmuc_return_from_interrupt_instr_e return_from_interrupt_instr_state_d;
    logic       fetch_en;
    logic       block_hit;
    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] rdata_d;
    logic       strobe_cycle;
    logic       strobe_n_d;
    logic       refetch_d;

    mmuc_map_if map_bus ();

    assign map_bus.bank_base           = bank_base_q;
    assign map_bus.common1_base        = common1_base_q;
    assign map_bus.common1_start_field = area_bounds_q[7:4];
    assign map_bus.bank_start_field    = area_bounds_q[3:0];

    mmuc_xlat u_xlat (
        .mclk        (mclk),
        .srst        (srst),
        .map         (map_bus),
        .log_addr    (log_addr),
        .phys_addr_q (phys_addr_q),
        .area_q      (area_q)
    );

    // the internal block sits in page zero of io space; relocation chooses 64 bytes of it
    assign block_hit = (io_addr[15:8] == 8'h00)
                       && (io_addr[7:6] == io_control_q[mmuc_pkg::BIT_RELOC_HI:mmuc_pkg::BIT_RELOC_LO]);
    assign wr_hit    = io_wr && block_hit;
    assign rd_hit    = io_rd && block_hit;
    assign fetch_en  = opt_control_q[mmuc_pkg::BIT_FETCH_EN];

    // decode on the low six bits; relocation only changes bits 7:6
    always_comb begin
        rdata_d = 8'h00;
        case (io_addr[5:0])
            mmuc_pkg::OFS_COMMON1_BASE[5:0]: rdata_d = common1_base_q;
            mmuc_pkg::OFS_BANK_BASE[5:0]:    rdata_d = bank_base_q;
            mmuc_pkg::OFS_AREA_BOUNDS[5:0]:  rdata_d = area_bounds_q;
            mmuc_pkg::OFS_OPT_CONTROL[5:0]:  rdata_d = opt_control_q;
            mmuc_pkg::OFS_IO_CONTROL[5:0]:   rdata_d = io_control_q;
            default:                         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            common1_base_q <= mmuc_pkg::RST_COMMON1_BASE;
            bank_base_q    <= mmuc_pkg::RST_BANK_BASE;
            area_bounds_q  <= mmuc_pkg::RST_AREA_BOUNDS;
            opt_control_q  <= mmuc_pkg::RST_OPT_CONTROL;
            io_control_q   <= mmuc_pkg::RST_IO_CONTROL;
        end else if (wr_hit) begin
            case (io_addr[5:0])
                mmuc_pkg::OFS_COMMON1_BASE[5:0]: common1_base_q <= io_wdata;
                mmuc_pkg::OFS_BANK_BASE[5:0]:    bank_base_q    <= io_wdata;
                mmuc_pkg::OFS_AREA_BOUNDS[5:0]:  area_bounds_q  <= io_wdata;
                mmuc_pkg::OFS_OPT_CONTROL[5:0]:  opt_control_q  <= io_wdata & mmuc_pkg::RST_OPT_CONTROL;
                // low bits unused here, kept zero
                mmuc_pkg::OFS_IO_CONTROL[5:0]:   io_control_q   <= io_wdata & 8'he0;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            io_rdata_q <= 8'h00;
            io_hit_q   <= 1'b0;
        end else begin
            io_rdata_q <= rd_hit ? rdata_d : 8'h00;
            io_hit_q   <= rd_hit || wr_hit;
        end
    end

    // return fetch: enabled mode fetches once; disabled mode adds a strobed refetch
    always_comb begin
        return_from_interrupt_instr_state_d = return_from_interrupt_instr_state_q;
        case (return_from_interrupt_instr_state_q)
            MMUC_IDLE:    return_from_interrupt_instr_state_d = (return_from_interrupt_instr_fetched && !fetch_en) ? MMUC_REFETCH : MMUC_IDLE;
            MMUC_REFETCH: return_from_interrupt_instr_state_d = MMUC_IDLE;
            default:      return_from_interrupt_instr_state_d = MMUC_IDLE;
        endcase
    end

    assign strobe_cycle = fetch_en ? (opcode_fetch || interrupt_line_zero_ack || nmi_ack_first)
                                   : (interrupt_line_zero_ack || nmi_ack_first);
    assign refetch_d    = return_from_interrupt_instr_state_q == MMUC_REFETCH;
    // the legacy refetch always carries the strobe so outside peripherals can decode it
    assign strobe_n_d   = !(strobe_cycle || refetch_d);

    always_ff @(posedge mclk) begin
        if (srst) begin
            return_from_interrupt_instr_state_q           <= MMUC_IDLE;
            fetch_cycle_strobe_n_q <= 1'b1;
            return_from_interrupt_instr_refetch_q         <= 1'b0;
            return_from_interrupt_instr_single_q          <= 1'b0;
            io_halt_mode_q         <= 1'b0;
        end else begin
            return_from_interrupt_instr_state_q           <= return_from_interrupt_instr_state_d;
            fetch_cycle_strobe_n_q <= strobe_n_d;
            return_from_interrupt_instr_refetch_q         <= refetch_d;
            return_from_interrupt_instr_single_q          <= return_from_interrupt_instr_fetched && fetch_en;
            io_halt_mode_q         <= io_control_q[mmuc_pkg::BIT_IO_HALT];
        end
    end

    sequence s_return_from_interrupt_instr_off;
        return_from_interrupt_instr_fetched && !fetch_en && return_from_interrupt_instr_state_q == MMUC_IDLE;
    endsequence
    sequence s_refetch_strobe;
        ##1 return_from_interrupt_instr_refetch_q ##0 (!fetch_cycle_strobe_n_q);
    endsequence

    a_reset_values: assert property (@(posedge mclk) srst |=> (bank_base_q == 8'h00 && area_bounds_q == 8'hff
        && opt_control_q[7] && io_control_q[7:6] == 2'b00 && common1_base_q == 8'h00))
        else $error("reset values wrong");
    a_strobe_fetch_on: assert property (@(posedge mclk) disable iff (srst)
        (fetch_en && opcode_fetch) |=> !fetch_cycle_strobe_n_q) else $error("strobe missing on fetch");
    a_strobe_fetch_off: assert property (@(posedge mclk) disable iff (srst)
        (!fetch_en && opcode_fetch && !interrupt_line_zero_ack && !nmi_ack_first && return_from_interrupt_instr_state_q == MMUC_IDLE)
        |=> fetch_cycle_strobe_n_q) else $error("strobe driven while disabled");
    a_return_from_interrupt_instr_refetch: assert property (@(posedge mclk) disable iff (srst)
        s_return_from_interrupt_instr_off |=> s_refetch_strobe) else $error("no strobed refetch");
    a_return_from_interrupt_instr_single: assert property (@(posedge mclk) disable iff (srst)
        (return_from_interrupt_instr_fetched && fetch_en && return_from_interrupt_instr_state_q == MMUC_IDLE) |=> ##1 !return_from_interrupt_instr_refetch_q)
        else $error("refetch in enabled mode");
    a_halt_follow: assert property (@(posedge mclk) disable iff (srst)
        (wr_hit && io_addr[5:0] == 6'h3f) |=> ##1 (io_halt_mode_q == $past(io_wdata[5], 2)))
        else $error("halt mode not following write");
    a_reloc_decode: assert property (@(posedge mclk) disable iff (srst)
        ((io_rd || io_wr) && io_addr[7:6] != io_control_q[7:6]) |=> !io_hit_q)
        else $error("decode outside relocated block");
    a_upper_byte: assert property (@(posedge mclk) disable iff (srst)
        ((io_rd || io_wr) && io_addr[15:8] != 8'h00) |=> !io_hit_q) else $error("upper io byte nonzero hit");
    a_bank_phys: assert property (@(posedge mclk) disable iff (srst)
        (log_addr[15:12] >= area_bounds_q[3:0] && log_addr[15:12] < area_bounds_q[7:4])
        |=> (area_q == 2'h1 && phys_addr_q[19] == 1'b0)) else $error("bank area map wrong");
    a_common1_phys: assert property (@(posedge mclk) disable iff (srst)
        (log_addr[15:12] >= area_bounds_q[7:4] && !wr_hit) |=> (area_q == 2'h2
        && phys_addr_q == 20'({4'h0, $past(log_addr)} + {common1_base_q, 12'h000})))
        else $error("common area 1 map wrong");
    a_common0_area: assert property (@(posedge mclk) disable iff (srst)
        (log_addr[15:12] < area_bounds_q[3:0] && log_addr[15:12] < area_bounds_q[7:4])
        |=> (area_q == 2'h0)) else $error("common area 0 encoding wrong");
    a_strobe_ack_any: assert property (@(posedge mclk) disable iff (srst)
        (interrupt_line_zero_ack || nmi_ack_first) |=> !fetch_cycle_strobe_n_q) else $error("strobe missing on acknowledge");
    a_strobe_idle: assert property (@(posedge mclk) disable iff (srst)
        (!opcode_fetch && !interrupt_line_zero_ack && !nmi_ack_first && return_from_interrupt_instr_state_q == MMUC_IDLE)
        |=> fetch_cycle_strobe_n_q) else $error("strobe without cause");
    a_miss_quiet: assert property (@(posedge mclk) disable iff (srst)
        (!io_rd && !io_wr) |=> (!io_hit_q && io_rdata_q == 8'h00)) else $error("answer without access");
    a_opt_mask: assert property (@(posedge mclk) disable iff (srst)
        (wr_hit && io_addr[5:0] == 6'h3e) |=> (opt_control_q[6:0] == 7'h00
        && opt_control_q[7] == $past(io_wdata[7]))) else $error("option write wrong");
    a_bank_write: assert property (@(posedge mclk) disable iff (srst)
        (wr_hit && io_addr[5:0] == 6'h39) |=> (bank_base_q == $past(io_wdata)))
        else $error("bank base write lost");
    a_single_pulse: assert property (@(posedge mclk) disable iff (srst)
        (return_from_interrupt_instr_fetched && fetch_en) |=> return_from_interrupt_instr_single_q) else $error("single return fetch not flagged");
endmodule // mmuc_regs

// ==== pkg/mmuc_pkg.sv ====
// shared constants for the mmu and mode control register bank
package mmuc_pkg;
    localparam logic [7:0]  OFS_COMMON1_BASE  = 8'h38;
    localparam logic [7:0]  OFS_BANK_BASE     = 8'h39;
    localparam logic [7:0]  OFS_AREA_BOUNDS   = 8'h3a;
    localparam logic [7:0]  OFS_OPT_CONTROL   = 8'h3e;
    localparam logic [7:0]  OFS_IO_CONTROL    = 8'h3f;
    localparam logic [5:0]  IO_BLOCK_MASK     = 6'h3f;
    localparam logic [7:0]  RST_COMMON1_BASE  = 8'h00;
    localparam logic [7:0]  RST_BANK_BASE     = 8'h00;
    localparam logic [7:0]  RST_AREA_BOUNDS   = 8'hff;
    localparam logic [7:0]  RST_OPT_CONTROL   = 8'h80;
    localparam logic [7:0]  RST_IO_CONTROL    = 8'h00;
    localparam int          BIT_FETCH_EN      = 7;
    localparam int          BIT_IO_HALT       = 5;
    localparam int          BIT_RELOC_HI      = 7;
    localparam int          BIT_RELOC_LO      = 6;
    localparam int          PAGE_SHIFT        = 12;
    localparam int          PHYS_W            = 20;
    localparam int          BANK_PHYS_W       = 19;
    localparam logic [1:0]  AREA_COMMON0      = 2'h0;
    localparam logic [1:0]  AREA_BANK         = 2'h1;
    localparam logic [1:0]  AREA_COMMON1      = 2'h2;
endpackage

// ==== pkg/mmuc_map_if.sv ====
// mapping settings passed from register bank to the address translator
`timescale 1ns/100ps
interface mmuc_map_if;
    logic [7:0] bank_base;
    logic [7:0] common1_base;
    logic [3:0] common1_start_field;
    logic [3:0] bank_start_field;
    modport regs (output bank_base, output common1_base, output common1_start_field, output bank_start_field);
    modport xlat (input bank_base, input common1_base, input common1_start_field, input bank_start_field);
endinterface

// ==== rtl/mmuc_xlat.sv ====
// logical to physical address translator, registered outputs
`timescale 1ns/100ps
module mmuc_xlat (
    input  wire logic        mclk,
    input  wire logic        srst,
    mmuc_map_if.xlat         map,
    input  wire logic [15:0] log_addr,
    output logic      [19:0] phys_addr_q,
    output logic      [1:0]  area_q
);
    logic [3:0]  page;
    logic        in_common1;
    logic        in_bank;
    logic [19:0] bank_sum;
    logic [19:0] common_sum;
    logic [19:0] phys_d;
    logic [1:0]  area_d;

    assign page       = log_addr[15:12];
    // common area 1 wins when both boundaries sit on the same page
    assign in_common1 = page >= map.common1_start_field;
    assign in_bank    = !in_common1 && (page >= map.bank_start_field);
    // bank area only reaches 19 bits, the top bit is forced low
    assign bank_sum   = {1'b0, 19'({4'h0, log_addr} + {map.bank_base, 12'h000})};
    // common area 1 wraps inside the 20-bit physical space
    assign common_sum = {4'h0, log_addr} + {map.common1_base, 12'h000};
    assign phys_d     = in_common1 ? common_sum : (in_bank ? bank_sum : {4'h0, log_addr});
    assign area_d     = in_common1 ? mmuc_pkg::AREA_COMMON1 : (in_bank ? mmuc_pkg::AREA_BANK : mmuc_pkg::AREA_COMMON0);

    always_ff @(posedge mclk) begin
        if (srst) begin
            phys_addr_q <= 20'h00000;
            area_q      <= mmuc_pkg::AREA_COMMON0;
        end else begin
            phys_addr_q <= phys_d;
            area_q      <= area_d;
        end
    end

    a_xlat_common0: assert property (@(posedge mclk) disable iff (srst)
        (log_addr[15:12] < map.bank_start_field && log_addr[15:12] < map.common1_start_field)
        |=> (phys_addr_q == {4'h0, $past(log_addr)})) else $error("common area 0 not passed through");
endmodule // mmuc_xlat

// ==== verification/mmuc_tb.sv ====
// self-checking testbench for the mmu and mode control register bank
`timescale 1ns/100ps
module testbench;
    logic        mclk;
    logic        srst;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic        io_wr;
    logic        io_rd;
    logic [15:0] log_addr;
    logic [3:0]  ev;
    logic [7:0]  io_rdata_q;
    logic        io_hit_q;
    logic [19:0] phys_addr_q;
    logic [1:0]  area_q;
    logic        strobe_n;
    logic        refetch_q;
    logic        single_q;
    logic        halt_q;
    int          err_count;
    int          n_compared;
    logic [7:0]  ofs [5] = '{mmuc_pkg::OFS_COMMON1_BASE, mmuc_pkg::OFS_BANK_BASE, mmuc_pkg::OFS_AREA_BOUNDS,
                             mmuc_pkg::OFS_OPT_CONTROL, mmuc_pkg::OFS_IO_CONTROL};
    logic [7:0]  rv  [5] = '{8'h00, 8'h00, 8'hff, 8'h80, 8'h00};

    mmuc_regs dut (
        .mclk                   (mclk),
        .srst                   (srst),
        .io_addr                (io_addr),
        .io_wdata               (io_wdata),
        .io_wr                  (io_wr),
        .io_rd                  (io_rd),
        .log_addr               (log_addr),
        .opcode_fetch           (ev[0]),
        .interrupt_line_zero_ack               (ev[1]),
        .nmi_ack_first          (ev[2]),
        .return_from_interrupt_instr_fetched           (ev[3]),
        .io_rdata_q             (io_rdata_q),
        .io_hit_q               (io_hit_q),
        .phys_addr_q            (phys_addr_q),
        .area_q                 (area_q),
        .fetch_cycle_strobe_n_q (strobe_n),
        .return_from_interrupt_instr_refetch_q         (refetch_q),
        .return_from_interrupt_instr_single_q          (single_q),
        .io_halt_mode_q         (halt_q)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // strobes are dropped a cycle before the next raise so no signal gets two values in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_addr = a; io_wdata = d; io_wr = 1'b1;
        @(negedge mclk); io_wr = 1'b0;
        @(negedge mclk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic hit);
        io_addr = a; io_rd = 1'b1;
        @(negedge mclk); io_rd = 1'b0;
        chk("io_rdata", io_rdata_q, exp);
        chk("io_hit", io_hit_q, hit);
        @(negedge mclk);
    endtask

    task automatic xl(input logic [15:0] la, input logic [1:0] ar, input logic [19:0] pa);
        log_addr = la;
        @(negedge mclk);
        chk("area", area_q, ar);
        chk("phys_addr", phys_addr_q, pa);
    endtask

    task automatic pulse(input logic [3:0] v, input logic s_n, input logic single);
        ev = v;
        @(negedge mclk); ev = 4'h0;
        chk("strobe_n", strobe_n, s_n);
        chk("return_from_interrupt_instr_single", single_q, single);
        @(negedge mclk);
    endtask

    task automatic do_reset();
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        for (int i = 0; i < 5; i++) rd(16'(ofs[i]), rv[i], 1'b1);
    endtask

    initial begin
        #(20 * 3000);
        err_count++;
        end_of_test();
    end

    initial begin
        err_count = 0; n_compared = 0;
        srst = 1'b1; io_addr = 16'h0000; io_wdata = 8'h00; io_wr = 1'b0; io_rd = 1'b0;
        log_addr = 16'h0000; ev = 4'h0;
        @(negedge mclk);
        do_reset();
        xl(16'hf123, 2'h2, 20'h0f123);
        xl(16'he123, 2'h0, 20'h0e123);
        wr(16'h0039, 8'hff);
        wr(16'h0038, 8'h20);
        wr(16'h003a, 8'hc4);
        rd(16'h0039, 8'hff, 1'b1);
        rd(16'h0038, 8'h20, 1'b1);
        rd(16'h003a, 8'hc4, 1'b1);
        xl(16'h3fff, 2'h0, 20'h03fff);
        xl(16'h4000, 2'h1, 20'h03000);
        xl(16'hbfff, 2'h1, 20'h0afff);
        xl(16'hc000, 2'h2, 20'h2c000);
        // fetch, acknowledge and return cycles with the enable set
        pulse(4'h1, 1'b0, 1'b0);
        pulse(4'h2, 1'b0, 1'b0);
        pulse(4'h4, 1'b0, 1'b0);
        pulse(4'h8, 1'b1, 1'b1);
        wr(16'h003e, 8'h00);
        rd(16'h003e, 8'h00, 1'b1);
        pulse(4'h1, 1'b1, 1'b0);
        pulse(4'h2, 1'b0, 1'b0);
        pulse(4'h8, 1'b1, 1'b0);
        chk("return_from_interrupt_instr_refetch", refetch_q, 1'b1);
        chk("strobe_n", strobe_n, 1'b0);
        rd(16'h003b, 8'h00, 1'b1);
        rd(16'h0139, 8'h00, 1'b0);
        for (int r = 1; r < 4; r++) begin
            wr({8'h00, 2'(r - 1), 6'h3f}, {2'(r), 6'h00});
            rd({8'h00, 2'(r), 6'h39}, 8'hff, 1'b1);
            rd({8'h00, 2'(r - 1), 6'h39}, 8'h00, 1'b0);
        end
        wr(16'h00ff, 8'h20);
        repeat (3) @(negedge mclk);
        chk("io_halt", halt_q, 1'b1);
        rd(16'h003f, 8'h20, 1'b1);
        wr(16'h003f, 8'h00);
        repeat (3) @(negedge mclk);
        chk("io_halt", halt_q, 1'b0);
        wr(16'h003f, 8'h20);
        repeat (3) @(negedge mclk);
        do_reset();
        chk("io_halt", halt_q, 1'b0);
        end_of_test();
    end
endmodule // testbench
